// >>> ppi_pkg.sv
// Package with register map, reset values and vector codes of the port block
package ppi_pkg;
  // Register indices; byte address is four times the index
  localparam logic [13:0] IDX_A_DIR = 14'h2004;
  localparam logic [13:0] IDX_A_DATA = 14'h2005;
  localparam logic [13:0] IDX_A_IRQ_EN = 14'h2006;
  localparam logic [13:0] IDX_A_FLAGS = 14'h2007;
  localparam logic [13:0] IDX_MODE_CTRL = 14'h2015;
  localparam logic [13:0] IDX_MOTOR_FLAGS = 14'h2017;
  localparam logic [13:0] IDX_B_DIR = 14'h2044;
  localparam logic [13:0] IDX_B_DATA = 14'h2045;
  localparam logic [13:0] IDX_B_IRQ_EN = 14'h2046;
  localparam logic [13:0] IDX_B_FLAGS = 14'h2047;
  localparam logic [13:0] IDX_A_FUNC_SEL = 14'h2049;
  localparam logic [13:0] IDX_MOTOR_IRQ_EN = 14'h2050;
  localparam int ADDR_W = 16;
  localparam int PORT_A_W = 9;
  localparam int PORT_B_W = 16;
  localparam int MODE_W = 9;
  // Field positions
  localparam int SEL_PIN7_ALT2_BIT = 14;
  localparam int SEL_PIN8_ALT2_BIT = 15;
  localparam int MODE_SERIAL_UART_BIT = 4;
  localparam int MOT_SYNC_BIT = 0;
  localparam int MOT_TRIP_BIT = 1;
  // Reset values
  localparam logic [15:0] FUNC_SEL_RST = 16'hFFFF;
  localparam logic [15:0] DIR_RST = 16'h0000;
  localparam logic [15:0] IRQ_EN_RST = 16'h0000;
  localparam logic [8:0] MODE_RST = 9'h000;
  localparam logic [1:0] MOTOR_EN_RST = 2'h0;
  // Vector codes of the pending source
  localparam logic [15:0] VEC_TRIP = 16'h002C;
  localparam logic [15:0] VEC_SYNC = 16'h000C;
  localparam logic [15:0] VEC_IO = 16'h0008;
  localparam logic [15:0] VEC_NONE = 16'h0000;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : ppi_pkg

// >>> ppi_top.sv
// Two programmable I/O ports with change flags and merged peripheral request
// What this block does
// - Provide 25 I/O pins: nine shared-function pins and 16 dedicated pins.
// - Function select bit n set makes shared pin n I/O, cleared routes alternate.
// - Function select resets to all ones, every shared pin starts as I/O.
// - Select bits 14, 15 pick pins 7, 8 second function; mode bit 4 pins 4, 5.
// - Direction bit cleared means input, set means driven output.
// - Both direction registers reset to zero, all lines inputs.
// - Data read returns pin levels on inputs, written levels on outputs; data write sets driven output levels.
// - Each line has its own interrupt enable, for inputs and outputs alike.
// - All interrupt enables reset to zero.
// - Enabled line triggers on either edge of its data bit, pin or write; a shared pin only while its select bit is set.
// - Such a change sets the line's change flag and raises shared I/O request.
// - Reading a change flag register returns then clears it, acknowledging it.
// - All 27 sources are maskable, prioritised and merged on one request line.
// - Rising edge of PWM cycle sync raises the sync interrupt.
// - Falling edge of PWM fault trip pin raises the trip interrupt.
// - Detected source sets its flag; request line held low while any pending.
// - Reading motor interrupt flags clears sync and trip bits.
// - Priority: trip 0x002C, then sync 0x000C, then I/O 0x0008.
// - Hardware, software or watchdog reset returns all registers to reset values.
//
// The register addresses and register access over AXI4-Lite were decided locally.
module ppi_top #(
  parameter int A_W = ppi_pkg::PORT_A_W,
  parameter int B_W = ppi_pkg::PORT_B_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic periph_reset,
  input wire logic [ppi_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ppi_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [A_W-1:0] shared_pin_in,
  output logic [A_W-1:0] shared_pin_out,
  output logic [A_W-1:0] shared_pin_oe,
  input wire logic [A_W-1:0] alt_func_out,
  input wire logic [A_W-1:0] alt_func_oe,
  input wire logic [B_W-1:0] dedicated_pin_in,
  output logic [B_W-1:0] dedicated_pin_out,
  output logic [B_W-1:0] dedicated_pin_oe,
  output logic shared_pin_7_alt2_sel,
  output logic shared_pin_8_alt2_sel,
  output logic serial_uart_mode,
  input wire logic pwm_cycle_sync,
  input wire logic pwm_fault_trip,
  output logic peripheral_request_line_n,
  output logic [15:0] irq_vector
);
  import ppi_pkg::*;

  typedef struct packed {
    logic [15:0] sel_a;
    logic [A_W-1:0] dir_a;
    logic [A_W-1:0] out_a;
    logic [A_W-1:0] en_a;
    logic [A_W-1:0] flg_a;
    logic [A_W-1:0] s1_a;
    logic [A_W-1:0] s2_a;
    logic [A_W-1:0] prev_a;
    logic [B_W-1:0] dir_b;
    logic [B_W-1:0] out_b;
    logic [B_W-1:0] en_b;
    logic [B_W-1:0] flg_b;
    logic [B_W-1:0] s1_b;
    logic [B_W-1:0] s2_b;
    logic [B_W-1:0] prev_b;
    logic [MODE_W-1:0] mode;
    logic [1:0] mot_en;
    logic [1:0] mot_flg;
    logic trip_s1;
    logic trip_s2;
    logic trip_prev;
    logic sync_prev;
    logic aw_ok;
    logic [13:0] aw_idx;
    logic w_ok;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic req_n;
    logic [15:0] vec;
  } ppi_state_t;

  ppi_state_t q;
  ppi_state_t d;
  logic rst_m;
  logic rst_s;

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m <= 1'b0;
      rst_s <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_s <= rst_m;
    end
  end

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] ppi_merge(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] st);
    logic [15:0] r;
    r = old;
    if (st[0]) begin
      r[7:0] = wd[7:0];
    end
    if (st[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction : ppi_merge

  logic [A_W-1:0] eff_a;
  logic [B_W-1:0] eff_b;
  logic [A_W-1:0] chg_a;
  logic [B_W-1:0] chg_b;
  logic sync_rise;
  logic trip_fall;
  logic rd_fire;
  logic [13:0] rd_idx;
  logic wr_do;

  // Data register value: driven level on outputs, synchronised pin on inputs
  assign eff_a = (q.dir_a & q.out_a) | (~q.dir_a & q.s2_a);
  assign eff_b = (q.dir_b & q.out_b) | (~q.dir_b & q.s2_b);
  // Either-edge change on enabled I/O lines; shared pins only in I/O mode
  assign chg_a = (eff_a ^ q.prev_a) & q.en_a & q.sel_a[A_W-1:0];
  assign chg_b = (eff_b ^ q.prev_b) & q.en_b;
  assign sync_rise = pwm_cycle_sync & ~q.sync_prev & q.mot_en[MOT_SYNC_BIT];
  assign trip_fall = ~q.trip_s2 & q.trip_prev & q.mot_en[MOT_TRIP_BIT];
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign rd_idx = s_axi_araddr[15:2];
  assign wr_do = q.aw_ok & q.w_ok & ~q.bvalid;

  always_comb begin
    logic [15:0] nv;
    logic hit;
    d = q;
    nv = 16'h0000;
    hit = 1'b0;
    // Synchronisers and edge history
    d.s1_a = shared_pin_in;
    d.s2_a = q.s1_a;
    d.s1_b = dedicated_pin_in;
    d.s2_b = q.s1_b;
    d.trip_s1 = pwm_fault_trip;
    d.trip_s2 = q.trip_s1;
    d.trip_prev = q.trip_s2;
    d.sync_prev = pwm_cycle_sync;
    d.prev_a = eff_a;
    d.prev_b = eff_b;
    // Write channel capture, either order
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_ok = 1'b1;
      d.aw_idx = s_axi_awaddr[15:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_ok = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (wr_do) begin
      d.aw_ok = 1'b0;
      d.w_ok = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      if (q.aw_idx == IDX_A_FUNC_SEL) begin
        d.sel_a = ppi_merge(q.sel_a, q.w_data, q.w_strb);
      end else if (q.aw_idx == IDX_A_DIR) begin
        nv = ppi_merge({7'h00, q.dir_a}, q.w_data, q.w_strb);
        d.dir_a = nv[A_W-1:0];
      end else if (q.aw_idx == IDX_A_DATA) begin
        nv = ppi_merge({7'h00, q.out_a}, q.w_data, q.w_strb);
        d.out_a = nv[A_W-1:0];
      end else if (q.aw_idx == IDX_A_IRQ_EN) begin
        nv = ppi_merge({7'h00, q.en_a}, q.w_data, q.w_strb);
        d.en_a = nv[A_W-1:0];
      end else if (q.aw_idx == IDX_B_DIR) begin
        d.dir_b = ppi_merge(q.dir_b, q.w_data, q.w_strb);
      end else if (q.aw_idx == IDX_B_DATA) begin
        d.out_b = ppi_merge(q.out_b, q.w_data, q.w_strb);
      end else if (q.aw_idx == IDX_B_IRQ_EN) begin
        d.en_b = ppi_merge(q.en_b, q.w_data, q.w_strb);
      end else if (q.aw_idx == IDX_MODE_CTRL) begin
        nv = ppi_merge({7'h00, q.mode}, q.w_data, q.w_strb);
        d.mode = nv[MODE_W-1:0];
      end else if (q.aw_idx == IDX_MOTOR_IRQ_EN) begin
        nv = ppi_merge({14'h0000, q.mot_en}, q.w_data, q.w_strb);
        d.mot_en = nv[1:0];
      end else if (q.aw_idx == IDX_A_FLAGS || q.aw_idx == IDX_B_FLAGS
                   || q.aw_idx == IDX_MOTOR_FLAGS) begin
        d.bresp = RESP_OKAY;
      end else begin
        d.bresp = RESP_SLVERR;
      end
    end
    // Read channel; flag reads clear their register
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (rd_fire) begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      hit = 1'b1;
      if (rd_idx == IDX_A_FUNC_SEL) begin
        nv = q.sel_a;
      end else if (rd_idx == IDX_A_DIR) begin
        nv = {7'h00, q.dir_a};
      end else if (rd_idx == IDX_A_DATA) begin
        nv = {7'h00, eff_a};
      end else if (rd_idx == IDX_A_IRQ_EN) begin
        nv = {7'h00, q.en_a};
      end else if (rd_idx == IDX_A_FLAGS) begin
        nv = {7'h00, q.flg_a};
        d.flg_a = '0;
      end else if (rd_idx == IDX_B_DIR) begin
        nv = q.dir_b;
      end else if (rd_idx == IDX_B_DATA) begin
        nv = eff_b;
      end else if (rd_idx == IDX_B_IRQ_EN) begin
        nv = q.en_b;
      end else if (rd_idx == IDX_B_FLAGS) begin
        nv = q.flg_b;
        d.flg_b = '0;
      end else if (rd_idx == IDX_MODE_CTRL) begin
        nv = {7'h00, q.mode};
      end else if (rd_idx == IDX_MOTOR_IRQ_EN) begin
        nv = {14'h0000, q.mot_en};
      end else if (rd_idx == IDX_MOTOR_FLAGS) begin
        nv = {14'h0000, q.mot_flg};
        d.mot_flg = 2'b00;
      end else begin
        hit = 1'b0;
      end
      d.rdata = {16'h0000, nv};
      if (!hit) begin
        d.rresp = RESP_SLVERR;
      end
    end
    // New events win over a clearing read in the same cycle
    d.flg_a = d.flg_a | chg_a;
    d.flg_b = d.flg_b | chg_b;
    d.mot_flg[MOT_SYNC_BIT] = d.mot_flg[MOT_SYNC_BIT] | sync_rise;
    d.mot_flg[MOT_TRIP_BIT] = d.mot_flg[MOT_TRIP_BIT] | trip_fall;
    // Peripheral reset of control and flag state
    if (periph_reset) begin
      d.sel_a = FUNC_SEL_RST;
      d.dir_a = DIR_RST[A_W-1:0];
      d.dir_b = DIR_RST[B_W-1:0];
      d.en_a = IRQ_EN_RST[A_W-1:0];
      d.en_b = IRQ_EN_RST[B_W-1:0];
      d.out_a = '0;
      d.out_b = '0;
      d.flg_a = '0;
      d.flg_b = '0;
      d.mode = MODE_RST;
      d.mot_en = MOTOR_EN_RST;
      d.mot_flg = 2'b00;
    end
    // Merged request and highest pending vector
    d.req_n = ~(|d.flg_a | |d.flg_b | |d.mot_flg);
    if (d.mot_flg[MOT_TRIP_BIT]) begin
      d.vec = VEC_TRIP;
    end else if (d.mot_flg[MOT_SYNC_BIT]) begin
      d.vec = VEC_SYNC;
    end else if (|d.flg_a || |d.flg_b) begin
      d.vec = VEC_IO;
    end else begin
      d.vec = VEC_NONE;
    end
  end

  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      q <= '0;
      q.sel_a <= FUNC_SEL_RST;
      q.req_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = ~q.aw_ok & ~q.bvalid;
  assign s_axi_wready = ~q.w_ok & ~q.bvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = ~q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;

  // Pin routing: I/O function or alternate function
  assign shared_pin_out = (q.sel_a[A_W-1:0] & q.out_a)
                          | (~q.sel_a[A_W-1:0] & alt_func_out);
  assign shared_pin_oe = (q.sel_a[A_W-1:0] & q.dir_a)
                         | (~q.sel_a[A_W-1:0] & alt_func_oe);
  assign dedicated_pin_out = q.out_b;
  assign dedicated_pin_oe = q.dir_b;
  assign shared_pin_7_alt2_sel = q.sel_a[SEL_PIN7_ALT2_BIT];
  assign shared_pin_8_alt2_sel = q.sel_a[SEL_PIN8_ALT2_BIT];
  assign serial_uart_mode = q.mode[MODE_SERIAL_UART_BIT];
  assign peripheral_request_line_n = q.req_n;
  assign irq_vector = q.vec;

  default clocking ppi_cb @(posedge clk);
  endclocking
  default disable iff (!rst_s);

  periph_reset_a: assert property (periph_reset |=>
      (q.sel_a == FUNC_SEL_RST && q.dir_b == '0
      && q.en_a == '0 && q.en_b == '0 && q.mot_flg == 2'b00))
    else $error("Peripheral reset left state set");
  request_low_a: assert property ($rose(q.mot_flg[MOT_TRIP_BIT])
      |-> !peripheral_request_line_n)
    else $error("Request line high with trip pending");
  flag_clear_a: assert property (rd_fire && rd_idx == IDX_B_FLAGS && chg_b == '0
      && !periph_reset |=> q.flg_b == '0 && s_axi_rvalid)
    else $error("Change flags not cleared by read");
  sync_edge_a: assert property (q.mot_en[MOT_SYNC_BIT] && !q.sync_prev && pwm_cycle_sync
      && !periph_reset |=> q.mot_flg[MOT_SYNC_BIT])
    else $error("Sync edge missed");
  trip_edge_a: assert property ($fell(q.trip_s2) && q.mot_en[MOT_TRIP_BIT]
      && !periph_reset |=> q.mot_flg[MOT_TRIP_BIT] && !peripheral_request_line_n)
    else $error("Trip edge missed");
  change_flag_a: assert property (chg_a != '0 && !periph_reset |=>
      (q.flg_a & $past(chg_a)) == $past(chg_a))
    else $error("Change flag not set");
  motor_clear_a: assert property (rd_fire && rd_idx == IDX_MOTOR_FLAGS && !sync_rise
      && !trip_fall |=> q.mot_flg == 2'b00)
    else $error("Motor flags not cleared by read");
  vector_prio_a: assert property (q.mot_flg[MOT_TRIP_BIT] |-> irq_vector == VEC_TRIP ##1
      (q.mot_flg[MOT_TRIP_BIT] || !q.mot_flg[MOT_SYNC_BIT] || irq_vector == VEC_SYNC))
    else $error("Wrong priority vector");

  trip_seen_c: cover property (trip_fall ##1 q.mot_flg[MOT_TRIP_BIT]);
  io_seen_c: cover property (chg_b != '0 ##1 !peripheral_request_line_n);
  both_pending_c: cover property (q.mot_flg[MOT_SYNC_BIT] && q.flg_a != '0);
  read_clear_c: cover property (rd_fire && rd_idx == IDX_A_FLAGS && q.flg_a != '0);
endmodule : ppi_top

// >>> ppi_far_model.sv
// Far-side model: pads with pull-downs, PWM event pins, core request input
module ppi_far_model (
  input wire logic [8:0] shared_pin_out,
  input wire logic [8:0] shared_pin_oe,
  input wire logic [15:0] dedicated_pin_out,
  input wire logic [15:0] dedicated_pin_oe,
  input wire logic [8:0] pad_a,
  input wire logic [8:0] pad_a_drv,
  input wire logic [15:0] pad_b,
  input wire logic [15:0] pad_b_drv,
  input wire logic sync_cmd,
  input wire logic trip_cmd,
  input wire logic [15:0] core_mask,
  input wire logic peripheral_request_line_n,
  output logic [8:0] shared_pin_in,
  output logic [15:0] dedicated_pin_in,
  output logic pwm_cycle_sync,
  output logic pwm_fault_trip,
  output logic core_irq_taken
);
  timeunit 1ns;
  timeprecision 100ps;
  // Undriven pads fall to the pull-down level
  assign shared_pin_in = (shared_pin_oe & shared_pin_out) | (~shared_pin_oe & pad_a_drv & pad_a);
  assign dedicated_pin_in = (dedicated_pin_oe & dedicated_pin_out)
    | (~dedicated_pin_oe & pad_b_drv & pad_b);
  assign pwm_cycle_sync = sync_cmd;
  assign pwm_fault_trip = trip_cmd;
  // Level-sensitive take, only with mask bit 9 set
  assign core_irq_taken = core_mask[9] & ~peripheral_request_line_n;
endmodule : ppi_far_model

// >>> ppi_top_tb.sv
// Self-checking testbench of the programmable I/O port block
module ppi_top_tb;
  import ppi_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n, periph_reset, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic sel7, sel8, uart, sync_cmd, trip_cmd, pwm_sync, pwm_trip, req_n, irq_taken;
  logic [15:0] awaddr, araddr, b_in, b_out, b_oe, pad_b, pad_b_drv, vec, core_mask;
  logic [31:0] wdata, rdata, rd_data;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rd_resp;
  logic [8:0] a_in, a_out, a_oe, alt_out, alt_oe, pad_a, pad_a_drv;
  int error_cnt, samples_checked;
  always #2.5 clk = ~clk;
  ppi_top DUT (.clk(clk), .rst_n(rst_n), .periph_reset(periph_reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .shared_pin_in(a_in), .shared_pin_out(a_out), .shared_pin_oe(a_oe),
    .alt_func_out(alt_out), .alt_func_oe(alt_oe), .dedicated_pin_in(b_in),
    .dedicated_pin_out(b_out), .dedicated_pin_oe(b_oe), .shared_pin_7_alt2_sel(sel7),
    .shared_pin_8_alt2_sel(sel8), .serial_uart_mode(uart), .pwm_cycle_sync(pwm_sync),
    .pwm_fault_trip(pwm_trip), .peripheral_request_line_n(req_n), .irq_vector(vec));
  ppi_far_model far (.shared_pin_out(a_out), .shared_pin_oe(a_oe),
    .dedicated_pin_out(b_out), .dedicated_pin_oe(b_oe), .pad_a(pad_a), .pad_a_drv(pad_a_drv),
    .pad_b(pad_b), .pad_b_drv(pad_b_drv), .sync_cmd(sync_cmd), .trip_cmd(trip_cmd),
    .core_mask(core_mask), .peripheral_request_line_n(req_n), .shared_pin_in(a_in),
    .dedicated_pin_in(b_in), .pwm_cycle_sync(pwm_sync), .pwm_fault_trip(pwm_trip),
    .core_irq_taken(irq_taken));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  task automatic hang;
    error_cnt++;
    $display("wrong value at %0t: wait ran out", $time);
    complete_run;
  endtask : hang
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [13:0] idx, input logic [15:0] d);
    logic a;
    logic w;
    logic b;
    logic [1:0] rsp;
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge clk);
      a = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      rsp = bresp;
      @(posedge clk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) begin
        chk({30'h0, rsp}, {30'h0, RESP_OKAY}, "write answer");
        return;
      end
    end
    hang;
  endtask : wr
  task automatic rd(input logic [13:0] idx);
    logic a;
    logic r;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge clk);
      a = arvalid & arready;
      r = rvalid;
      rd_data = rdata;
      rd_resp = rresp;
      @(posedge clk);
      if (a) arvalid <= 1'b0;
      if (r) begin
        return;
      end
    end
    hang;
  endtask : rd
  task automatic rchk(input logic [13:0] idx, input logic [15:0] exp, input string what);
    rd(idx);
    chk(rd_data, {16'h0000, exp}, what);
    chk({30'h0, rd_resp}, {30'h0, RESP_OKAY}, "read answer");
  endtask : rchk
  task automatic wait_req(input logic lvl);
    for (int n = 0; n < 20; n++) begin
      @(negedge clk);
      if (req_n === lvl) begin
        @(posedge clk);
        return;
      end
    end
    hang;
  endtask : wait_req
  task automatic t_reset;
    rchk(IDX_A_FUNC_SEL, FUNC_SEL_RST, "select reset");
    rchk(IDX_A_DIR, DIR_RST, "A dir reset");
    rchk(IDX_B_DIR, DIR_RST, "B dir reset");
    rchk(IDX_A_IRQ_EN, IRQ_EN_RST, "A enable reset");
    rchk(IDX_B_IRQ_EN, IRQ_EN_RST, "B enable reset");
    chk({7'h0, a_oe, b_oe}, 32'h0000_0000, "pins not driven");
    rd(14'h2014);
    chk({30'h0, rd_resp}, {30'h0, RESP_SLVERR}, "unmapped read");
    $display("test reset done");
  endtask : t_reset
  task automatic t_output;
    pad_b <= 16'h003C;
    wr(IDX_B_DIR, 16'hFF00);
    wr(IDX_B_DATA, 16'hA5C3);
    chk({16'h0, b_oe}, 32'h0000_FF00, "B drive enable");
    chk({16'h0, b_out & b_oe}, 32'h0000_A500, "B driven levels");
    rchk(IDX_B_DATA, 16'hA53C, "B mixed read");
    wr(IDX_A_DIR, 16'h01FF);
    wr(IDX_A_DATA, 16'h0155);
    chk({23'h0, a_out & a_oe}, 32'h0000_0155, "A driven levels");
    $display("test output done");
  endtask : t_output
  task automatic t_change;
    wr(IDX_B_DIR, 16'h0000);
    wr(IDX_B_IRQ_EN, 16'h8001);
    pad_b <= 16'h803F;
    wait_req(1'b0);
    chk({31'h0, irq_taken}, 32'h0000_0001, "core takes request");
    chk({16'h0, vec}, {16'h0, VEC_IO}, "io vector");
    rchk(IDX_B_FLAGS, 16'h8001, "rising flags");
    rchk(IDX_B_FLAGS, 16'h0000, "flags cleared");
    wait_req(1'b1);
    pad_b <= 16'h003E;
    wait_req(1'b0);
    rchk(IDX_B_FLAGS, 16'h8001, "falling flags");
    wr(IDX_A_IRQ_EN, 16'h0001);
    wr(IDX_A_DATA, 16'h0154);
    wait_req(1'b0);
    rchk(IDX_A_FLAGS, 16'h0001, "written change");
    wait_req(1'b1);
    $display("test change done");
  endtask : t_change
  task automatic t_select;
    wr(IDX_A_FUNC_SEL, 16'hC0FB);
    chk({30'h0, a_oe[2], a_out[2]}, 32'h0000_0002, "alternate drive");
    chk({30'h0, sel8, sel7}, 32'h0000_0003, "second functions");
    wstrb <= 4'h1;
    wr(IDX_MODE_CTRL, 16'hFF10);
    wstrb <= 4'hF;
    chk({31'h0, uart}, 32'h0000_0001, "serial mode");
    rchk(IDX_MODE_CTRL, 16'h0010, "low lane only");
    $display("test select done");
  endtask : t_select
  task automatic t_pwm;
    wr(IDX_MOTOR_IRQ_EN, 16'h0003);
    sync_cmd <= 1'b1;
    trip_cmd <= 1'b0;
    pad_b <= 16'h003F;
    @(posedge clk);
    sync_cmd <= 1'b0;
    wait_req(1'b0);
    repeat (4) @(posedge clk);
    chk({16'h0, vec}, {16'h0, VEC_TRIP}, "trip first");
    rchk(IDX_MOTOR_FLAGS, 16'h0003, "motor flags");
    repeat (2) @(posedge clk);
    chk({16'h0, vec}, {16'h0, VEC_IO}, "io after motor");
    rchk(IDX_B_FLAGS, 16'h0001, "io pending");
    wait_req(1'b1);
    trip_cmd <= 1'b1;
    sync_cmd <= 1'b1;
    @(posedge clk);
    sync_cmd <= 1'b0;
    wait_req(1'b0);
    repeat (2) @(posedge clk);
    chk({16'h0, vec}, {16'h0, VEC_SYNC}, "sync vector");
    rchk(IDX_MOTOR_FLAGS, 16'h0001, "sync only");
    wait_req(1'b1);
    wr(IDX_MOTOR_IRQ_EN, 16'h0000);
    sync_cmd <= 1'b1;
    @(posedge clk);
    sync_cmd <= 1'b0;
    repeat (6) @(posedge clk);
    chk({31'h0, req_n}, 32'h0000_0001, "masked sync");
    $display("test pwm done");
  endtask : t_pwm
  task automatic t_soft;
    wr(IDX_B_DIR, 16'h00FF);
    wr(IDX_A_FUNC_SEL, 16'h0000);
    periph_reset <= 1'b1;
    @(posedge clk);
    periph_reset <= 1'b0;
    @(posedge clk);
    rchk(IDX_A_FUNC_SEL, FUNC_SEL_RST, "select after reset");
    rchk(IDX_B_DIR, DIR_RST, "dir after reset");
    chk({29'h0, sel8, sel7, uart}, 32'h0000_0006, "modes after reset");
    $display("test soft reset done");
  endtask : t_soft
  initial begin
    {clk, rst_n, periph_reset, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
    {awaddr, araddr, wdata, pad_a, pad_a_drv, pad_b} = '0;
    wstrb = 4'hF;
    pad_b_drv = 16'hFFFF;
    alt_out = 9'h0AA;
    alt_oe = 9'h1F4;
    sync_cmd = 1'b0;
    trip_cmd = 1'b1;
    core_mask = 16'h0200;
    error_cnt = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_output;
    t_change;
    t_select;
    t_pwm;
    t_soft;
    complete_run;
  end
endmodule : ppi_top_tb
